// >>> rtl/cpurg_regs.sv
// CPU programmer-model registers: A, H:X, SP, PC and condition flags.
//
// Contract
// - Accumulator is 8-bit, feeds the arithmetic unit, reset leaves it.
// - H and X form a 16-bit pointer used by indexed accesses.
// - Reset clears H, X keeps its value.
// - X works as a data register: clear, inc, dec, com, neg, shifts.
// - Stack pointer is 16-bit, points at next free stack byte.
// - Calls push return address; interrupts push it plus registers.
// - Reset loads stack pointer with 0x00FF.
// - Add-immediate-to-stack adds a sign-extended byte to the full SP.
// - Reset-stack-low changes only the low SP byte.
// - PC increments on each fetched instruction or operand byte.
// - Jump, branch, call and interrupt load a new PC.
// - After reset PC holds the vector read from 0xFFFE and 0xFFFF.
// - Registers take no memory address; one 64-Kbyte space for all.
// - Direct addressing reaches 0x0000 to 0x00FF only.
// - Branch target is PC plus a signed byte displacement.
// - Datapath offers 8x8 multiply and 16/8 divide.
// - Condition flags bits 6 and 5 always read one.
// - Interrupt mask sets with the last frame byte push, before the handler runs.
`timescale 1ns/1ns
`default_nettype none
module cpurg_regs
(
    // Clock and reset.
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst,
    // Decoder command, taken while o_busy is low.
    input  wire cpurg_pkg::cpurg_cmd_t i_cmd,
    // Read data, valid the cycle after a read request is shown.
    input  wire logic [7:0]           i_mem_rdata,
    // Memory request.
    output var cpurg_pkg::cpurg_mem_t o_mem,
    // Register contents.
    output logic [7:0]                o_acc,
    output logic [15:0]               o_hx,
    output logic [15:0]               o_sp,
    output logic [15:0]               o_pc,
    output logic [7:0]                o_ccr,
    output logic                      o_busy
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    cpurg_pkg::cpurg_state_t state;
    cpurg_pkg::cpurg_state_t next_state;
    cpurg_pkg::cpurg_mem_t   next_mem;
    logic [7:0]  x_reg;
    logic [7:0]  h_reg;
    logic [7:0]  next_acc;
    logic [7:0]  next_x;
    logic [7:0]  next_h;
    logic [15:0] next_sp;
    logic [15:0] next_pc;
    logic [7:0]  next_ccr;
    logic        next_busy;
    logic [2:0]  push_idx;
    logic [2:0]  next_push_idx;
    logic [2:0]  push_len;
    logic [2:0]  next_push_len;
    logic [15:0] target;
    logic [15:0] next_target;
    logic [15:0] prod;
    logic [7:0]  quot;
    logic [7:0]  rem;
    logic        div_err;
    logic        take;

    // Sign extension of a byte, used by stack adjust and branches.
    function automatic logic [15:0] sext8(input logic [7:0] v);
        sext8 = {{8{v[7]}}, v};
    endfunction

    // Flag update from an 8-bit result; bits 6 and 5 forced high.
    function automatic logic [7:0] flags8(input logic [7:0] c,
                                           input logic [7:0] r,
                                           input logic       cy);
        logic [7:0] f;
        f        = c;
        f[cpurg_pkg::CCR_N] = r[7];
        f[cpurg_pkg::CCR_Z] = (r == 8'h00);
        f[cpurg_pkg::CCR_C] = cy;
        flags8   = f | cpurg_pkg::CCR_ONES;
    endfunction

    // Stack frame byte order: PC low, PC high, X, A, flags.
    function automatic logic [7:0] frame_byte(input logic [2:0]  idx,
                                               input logic [15:0] ret);
        case (idx)
            3'h0:    frame_byte = ret[7:0];
            3'h1:    frame_byte = ret[15:8];
            3'h2:    frame_byte = x_reg;
            3'h3:    frame_byte = o_acc;
            default: frame_byte = o_ccr;
        endcase
    endfunction

    assign take = (state == cpurg_pkg::ST_RUN) &&
                  (i_cmd.op != cpurg_pkg::OP_NOP);

    // Multiply and divide on A, X and H.
    cpurg_mdu u_mdu
    (
        .i_acc     (o_acc),
        .i_x       (x_reg),
        .i_h       (o_hx[15:8]),
        .o_prod    (prod),
        .o_quot    (quot),
        .o_rem     (rem),
        .o_div_err (div_err)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // All register updates are decided here; the memory bus is never
    // used for the registers themselves, so no address decodes them.
    always_comb
    begin
        next_state    = state;
        next_mem      = '0;
        next_acc      = o_acc;
        next_x        = x_reg;
        next_h        = o_hx[15:8];
        next_sp       = o_sp;
        next_pc       = o_pc;
        next_ccr      = o_ccr;
        next_busy     = 1'b1;
        next_push_idx = push_idx;
        next_push_len = push_len;
        next_target   = target;
        case (state)
            cpurg_pkg::ST_VEC_HI:
            begin
                next_mem.rd   = 1'b1;
                next_mem.addr = cpurg_pkg::VEC_ADDR_HI;
                next_state    = cpurg_pkg::ST_VEC_LO;
            end
            cpurg_pkg::ST_VEC_LO:
            begin
                next_mem.rd   = 1'b1;
                next_mem.addr = cpurg_pkg::VEC_ADDR_LO;
                next_state    = cpurg_pkg::ST_VEC_CAP;
            end
            cpurg_pkg::ST_VEC_CAP:
            begin
                next_pc[15:8] = i_mem_rdata;
                next_state    = cpurg_pkg::ST_VEC_END;
            end
            cpurg_pkg::ST_VEC_END:
            begin
                next_pc[7:0]  = i_mem_rdata;
                next_busy     = 1'b0;
                next_state    = cpurg_pkg::ST_RUN;
            end
            cpurg_pkg::ST_PUSH:
            begin
                // Push writes at SP, then SP steps down.
                next_mem.wr    = 1'b1;
                next_mem.addr  = o_sp;
                next_mem.wdata = frame_byte(push_idx, o_pc);
                next_sp        = o_sp - 16'h0001;
                next_push_idx  = push_idx + 3'h1;
                if (push_idx == push_len - 3'h1)
                begin
                    next_pc    = target;
                    next_busy  = 1'b0;
                    next_state = cpurg_pkg::ST_RUN;
                    // Mask only with the write of the last frame byte.
                    if (push_len == cpurg_pkg::IRQ_FRAME)
                        next_ccr[cpurg_pkg::CCR_I] = 1'b1;
                end
            end
            cpurg_pkg::ST_RUN:
            begin
                next_busy = 1'b0;
                case (i_cmd.op)
                    cpurg_pkg::OP_FETCH:
                        next_pc = o_pc + 16'h0001;
                    cpurg_pkg::OP_LD_A:
                        next_acc = i_cmd.data8;
                    cpurg_pkg::OP_LD_X:
                        next_x = i_cmd.data8;
                    cpurg_pkg::OP_LD_HX:
                    begin
                        next_h = i_cmd.data16[15:8];
                        next_x = i_cmd.data16[7:0];
                    end
                    cpurg_pkg::OP_LD_SP:
                        next_sp = i_cmd.data16;
                    cpurg_pkg::OP_LD_CCR:
                        next_ccr = i_cmd.data8 | cpurg_pkg::CCR_ONES;
                    cpurg_pkg::OP_X_CLR:
                        next_x = 8'h00;
                    cpurg_pkg::OP_X_INC:
                        next_x = x_reg + 8'h01;
                    cpurg_pkg::OP_X_DEC:
                        next_x = x_reg - 8'h01;
                    cpurg_pkg::OP_X_COM:
                        next_x = ~x_reg;
                    cpurg_pkg::OP_X_NEG:
                        next_x = 8'h00 - x_reg;
                    cpurg_pkg::OP_X_LSL:
                        next_x = {x_reg[6:0], 1'b0};
                    cpurg_pkg::OP_X_LSR:
                        next_x = {1'b0, x_reg[7:1]};
                    cpurg_pkg::OP_X_ROL:
                        next_x = {x_reg[6:0], o_ccr[cpurg_pkg::CCR_C]};
                    cpurg_pkg::OP_X_ROR:
                        next_x = {o_ccr[cpurg_pkg::CCR_C], x_reg[7:1]};
                    cpurg_pkg::OP_AIS:
                        next_sp = o_sp + sext8(i_cmd.data8);
                    cpurg_pkg::OP_RSP:
                        next_sp = {o_sp[15:8], cpurg_pkg::SP_LOW_RESET};
                    cpurg_pkg::OP_JUMP:
                        next_pc = i_cmd.data16;
                    cpurg_pkg::OP_BRANCH:
                        if (i_cmd.cond)
                            next_pc = o_pc + sext8(i_cmd.data8);
                    cpurg_pkg::OP_MUL:
                    begin
                        next_x   = prod[15:8];
                        next_acc = prod[7:0];
                        next_ccr[cpurg_pkg::CCR_C] = 1'b0;
                    end
                    cpurg_pkg::OP_DIV:
                    begin
                        // On error the operands are kept for software.
                        if (!div_err)
                        begin
                            next_acc = quot;
                            next_h   = rem;
                        end
                        next_ccr[cpurg_pkg::CCR_C] = div_err;
                    end
                    cpurg_pkg::OP_DIR_RD:
                    begin
                        next_mem.rd   = 1'b1;
                        next_mem.addr = {cpurg_pkg::DIRECT_PAGE_HI,
                                         i_cmd.data8};
                    end
                    cpurg_pkg::OP_IDX_RD:
                    begin
                        next_mem.rd   = 1'b1;
                        next_mem.addr = o_hx + i_cmd.data16;
                    end
                    cpurg_pkg::OP_PUSH_A:
                    begin
                        next_mem.wr    = 1'b1;
                        next_mem.addr  = o_sp;
                        next_mem.wdata = o_acc;
                        next_sp        = o_sp - 16'h0001;
                    end
                    cpurg_pkg::OP_PULL:
                    begin
                        next_sp       = o_sp + 16'h0001;
                        next_mem.rd   = 1'b1;
                        next_mem.addr = o_sp + 16'h0001;
                    end
                    cpurg_pkg::OP_CALL, cpurg_pkg::OP_IRQ:
                    begin
                        next_target   = i_cmd.data16;
                        next_push_idx = 3'h0;
                        next_push_len = (i_cmd.op == cpurg_pkg::OP_IRQ) ?
                                        cpurg_pkg::IRQ_FRAME :
                                        cpurg_pkg::CALL_FRAME;
                        next_busy     = 1'b1;
                        next_state    = cpurg_pkg::ST_PUSH;
                    end
                    default:
                        next_busy = 1'b0;
                endcase
                // X data operations update N and Z from the result; shifts and rotates set C from the bit shifted out.
                if ((i_cmd.op >= cpurg_pkg::OP_X_CLR) &&
                    (i_cmd.op <= cpurg_pkg::OP_X_ROR))
                    next_ccr = flags8(o_ccr, next_x,
                        (i_cmd.op == cpurg_pkg::OP_X_LSL ||
                         i_cmd.op == cpurg_pkg::OP_X_ROL) ? x_reg[7] :
                        (i_cmd.op == cpurg_pkg::OP_X_LSR ||
                         i_cmd.op == cpurg_pkg::OP_X_ROR) ? x_reg[0] :
                        o_ccr[cpurg_pkg::CCR_C]);
            end
            default:
                next_state = cpurg_pkg::ST_VEC_HI;
        endcase
        next_ccr = next_ccr | cpurg_pkg::CCR_ONES;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Control state and pointers take their reset values here.
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state      <= cpurg_pkg::ST_VEC_HI;
            o_mem      <= '0;
            h_reg      <= cpurg_pkg::H_RESET;
            o_sp       <= cpurg_pkg::SP_RESET;
            o_pc       <= 16'h0000;
            o_ccr      <= cpurg_pkg::CCR_RESET;
            o_busy     <= 1'b1;
            push_idx   <= 3'h0;
            push_len   <= 3'h0;
            target     <= 16'h0000;
        end
        else
        begin
            state      <= next_state;
            o_mem      <= next_mem;
            h_reg      <= next_h;
            o_sp       <= next_sp;
            o_pc       <= next_pc;
            o_ccr      <= next_ccr;
            o_busy     <= next_busy;
            push_idx   <= next_push_idx;
            push_len   <= next_push_len;
            target     <= next_target;
        end
    end

    // A and X have no reset, so reset leaves their contents untouched.
    // Their value after power-up is unknown until software loads them.
    always_ff @(posedge i_sys_clk)
    begin
        o_acc     <= next_acc;
        x_reg     <= next_x;
    end

    // One driver per byte register; H:X is their plain concatenation.
    assign o_hx = {h_reg, x_reg};

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    property p_reset_ptrs;
        (state == cpurg_pkg::ST_VEC_HI) |->
            (o_sp == 16'h00FF) && (o_hx[15:8] == 8'h00);
    endproperty
    a_reset_ptrs: assert property (p_reset_ptrs)
        else $error("SP or H wrong after reset");

    property p_vector;
        (state == cpurg_pkg::ST_VEC_END) |=>
            (o_pc == {$past(i_mem_rdata, 2), $past(i_mem_rdata, 1)})
            && !o_busy;
    endproperty
    a_vector: assert property (p_vector)
        else $error("PC not loaded from reset vector");

    property p_vec_addr;
        (state == cpurg_pkg::ST_VEC_HI) |=>
            (o_mem.rd && o_mem.addr == 16'hFFFE) ##1
            (o_mem.rd && o_mem.addr == 16'hFFFF);
    endproperty
    a_vec_addr: assert property (p_vec_addr)
        else $error("Vector reads at wrong addresses");

    property p_fetch;
        (take && i_cmd.op == cpurg_pkg::OP_FETCH) |=>
            (o_pc == $past(o_pc) + 16'h0001);
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("PC did not step on fetch");

    property p_jump;
        (take && i_cmd.op == cpurg_pkg::OP_JUMP) |=>
            (o_pc == $past(i_cmd.data16));
    endproperty
    a_jump: assert property (p_jump)
        else $error("Jump target not loaded");

    property p_branch;
        (take && i_cmd.op == cpurg_pkg::OP_BRANCH && i_cmd.cond) |=>
            (o_pc == $past(o_pc) + {{8{$past(i_cmd.data8[7])}},
                                    $past(i_cmd.data8)});
    endproperty
    a_branch: assert property (p_branch)
        else $error("Branch target wrong");

    property p_ais;
        (take && i_cmd.op == cpurg_pkg::OP_AIS) |=>
            (o_sp == $past(o_sp) + {{8{$past(i_cmd.data8[7])}},
                                    $past(i_cmd.data8)});
    endproperty
    a_ais: assert property (p_ais)
        else $error("Stack adjust wrong");

    property p_rsp;
        (take && i_cmd.op == cpurg_pkg::OP_RSP) |=>
            (o_sp[15:8] == $past(o_sp[15:8])) && (o_sp[7:0] == 8'hFF);
    endproperty
    a_rsp: assert property (p_rsp)
        else $error("Stack low reset touched high byte");

    property p_push;
        (take && i_cmd.op == cpurg_pkg::OP_PUSH_A) |=>
            o_mem.wr && (o_mem.addr == $past(o_sp)) &&
            (o_sp == $past(o_sp) - 16'h0001);
    endproperty
    a_push: assert property (p_push)
        else $error("Push order wrong");

    property p_irq;
        (take && i_cmd.op == cpurg_pkg::OP_IRQ) |=>
            (!o_ccr[3] || $past(o_ccr[3])) [*5] ##1
            (o_ccr[3] && o_pc == $past(i_cmd.data16, 6) &&
             o_sp == $past(o_sp, 6) - 16'h0005);
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt entry sequence wrong");

    property p_direct;
        (take && i_cmd.op == cpurg_pkg::OP_DIR_RD) |=>
            o_mem.rd && (o_mem.addr[15:8] == 8'h00);
    endproperty
    a_direct: assert property (p_direct)
        else $error("Direct access left page zero");

    property p_ccr_ones;
        (take && i_cmd.op == cpurg_pkg::OP_LD_CCR) |=>
            (o_ccr[6:5] == 2'b11);
    endproperty
    a_ccr_ones: assert property (p_ccr_ones)
        else $error("Flag bits 6 and 5 not one");

    c_irq:  cover property (take && i_cmd.op == cpurg_pkg::OP_IRQ);
    c_call: cover property (take && i_cmd.op == cpurg_pkg::OP_CALL);
    c_div:  cover property (take && i_cmd.op == cpurg_pkg::OP_DIV
                            && !div_err);

endmodule // cpurg_regs
`default_nettype wire

// >>> rtl/cpurg_pkg.sv
// Shared constants and types for the CPU programmer-model register block.
package cpurg_pkg;

    // ------------------------------------------------------------------
    // Reset values and fixed addresses
    // ------------------------------------------------------------------
    localparam logic [7:0]  H_RESET        = 8'h00;
    localparam logic [15:0] SP_RESET       = 16'h00FF;
    localparam logic [7:0]  SP_LOW_RESET   = 8'hFF;
    localparam logic [15:0] VEC_ADDR_HI    = 16'hFFFE;
    localparam logic [15:0] VEC_ADDR_LO    = 16'hFFFF;
    localparam logic [7:0]  DIRECT_PAGE_HI = 8'h00;

    // ------------------------------------------------------------------
    // Condition flags layout
    // ------------------------------------------------------------------
    localparam logic [7:0] CCR_ONES    = 8'h60;
    localparam logic [7:0] CCR_RESET   = 8'h68;
    localparam int         CCR_C       = 0;
    localparam int         CCR_Z       = 1;
    localparam int         CCR_N       = 2;
    localparam int         CCR_I       = 3;

    // ------------------------------------------------------------------
    // Stack frame lengths in bytes
    // ------------------------------------------------------------------
    localparam logic [2:0] CALL_FRAME  = 3'h2;
    localparam logic [2:0] IRQ_FRAME   = 3'h5;

    // Operations issued by the instruction decoder.
    typedef enum logic [4:0] {
        OP_NOP    = 5'b00000,
        OP_FETCH  = 5'b00001,
        OP_LD_A   = 5'b00010,
        OP_LD_X   = 5'b00011,
        OP_LD_HX  = 5'b00100,
        OP_LD_SP  = 5'b00101,
        OP_LD_CCR = 5'b00110,
        OP_X_CLR  = 5'b00111,
        OP_X_INC  = 5'b01000,
        OP_X_DEC  = 5'b01001,
        OP_X_COM  = 5'b01010,
        OP_X_NEG  = 5'b01011,
        OP_X_LSL  = 5'b01100,
        OP_X_LSR  = 5'b01101,
        OP_X_ROL  = 5'b01110,
        OP_X_ROR  = 5'b01111,
        OP_AIS    = 5'b10000,
        OP_RSP    = 5'b10001,
        OP_JUMP   = 5'b10010,
        OP_BRANCH = 5'b10011,
        OP_MUL    = 5'b10100,
        OP_DIV    = 5'b10101,
        OP_DIR_RD = 5'b10110,
        OP_IDX_RD = 5'b10111,
        OP_PUSH_A = 5'b11000,
        OP_PULL   = 5'b11001,
        OP_CALL   = 5'b11010,
        OP_IRQ    = 5'b11011
    } cpurg_op_t;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_VEC_HI  = 3'b000,
        ST_VEC_LO  = 3'b001,
        ST_VEC_CAP = 3'b010,
        ST_VEC_END = 3'b011,
        ST_RUN     = 3'b100,
        ST_PUSH    = 3'b101
    } cpurg_state_t;

    // Command from the decoder.
    typedef struct packed {
        cpurg_op_t   op;
        logic        cond;
        logic [7:0]  data8;
        logic [15:0] data16;
    } cpurg_cmd_t;

    // Memory request toward the single 64-Kbyte space.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cpurg_mem_t;

endpackage

// >>> rtl/cpurg_mdu.sv
// Multiply and divide unit for the CPU register block.
`timescale 1ns/1ns
`default_nettype none
module cpurg_mdu
(
    // Operands.
    input  wire logic [7:0]  i_acc,
    input  wire logic [7:0]  i_x,
    input  wire logic [7:0]  i_h,
    // Results.
    output logic      [15:0] o_prod,
    output logic      [7:0]  o_quot,
    output logic      [7:0]  o_rem,
    output logic             o_div_err
);

    logic [15:0] dividend;
    logic [15:0] quot_wide;

    // Quotient wider than a byte or a zero divisor is an error.
    always_comb
    begin
        dividend  = {i_h, i_acc};
        o_prod    = 16'(i_acc * i_x);
        quot_wide = 16'h0000;
        o_rem     = 8'h00;
        if (i_x != 8'h00)
        begin
            quot_wide = dividend / {8'h00, i_x};
            o_rem     = 8'(dividend % {8'h00, i_x});
        end
        o_quot    = quot_wide[7:0];
        o_div_err = (i_x == 8'h00) || (quot_wide[15:8] != 8'h00);
    end

endmodule // cpurg_mdu
`default_nettype wire

// >>> test/cpu_programmer_model_regs_tb.sv
// Self-checking bench for the CPU programmer-model register block.
`timescale 1ns/1ns
`default_nettype none
module cpu_programmer_model_regs_tb;
    // ------------------------------------------------------------------
    // Stimulus, observed outputs and counters
    // ------------------------------------------------------------------
    logic                  i_sys_clk   = 1'b0;
    logic                  i_rst       = 1'b1;
    cpurg_pkg::cpurg_cmd_t cmd         = '0;
    logic [7:0]            rdata       = 8'h00;
    cpurg_pkg::cpurg_mem_t mem;
    logic [7:0]            acc, condition_flags_reg;
    logic [15:0]           hx, sp, pc, s16;
    logic [8:0]            e9;
    logic [39:0]           frame;
    logic                  busy;
    logic [31:0]           rnd         = 32'h5f73;
    int                    fail_count  = 0;
    int                    checks_done = 0;

    cpurg_regs cpurg_regs_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_cmd(cmd), .i_mem_rdata(rdata), .o_mem(mem), .o_acc(acc),
        .o_hx(hx), .o_sp(sp), .o_pc(pc), .o_ccr(condition_flags_reg), .o_busy(busy));

    // Free-running 100 MHz clock.
    initial
    begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    // Galois shift register; the fixed seed keeps every run the same.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
    endfunction

    // Widens a signed byte, as the stack and branch adders must.
    function automatic logic [15:0] sx(input logic [7:0] b);
        return {{8{b[7]}}, b};
    endfunction

    // Expected carry and result of a data operation on X.
    function automatic logic [8:0] xop(input cpurg_pkg::cpurg_op_t op,
                                       input logic [7:0] x, input logic c);
        case (op)
            cpurg_pkg::OP_X_CLR: return {c, 8'h00};
            cpurg_pkg::OP_X_INC: return {c, 8'(x + 8'h01)};
            cpurg_pkg::OP_X_DEC: return {c, 8'(x - 8'h01)};
            cpurg_pkg::OP_X_COM: return {c, ~x};
            cpurg_pkg::OP_X_NEG: return {c, 8'(8'h00 - x)};
            cpurg_pkg::OP_X_LSL: return {x, 1'b0};
            cpurg_pkg::OP_X_LSR: return {x[0], 1'b0, x[7:1]};
            cpurg_pkg::OP_X_ROL: return {x, c};
            default:             return {x[0], c, x[7:1]};
        endcase
    endfunction

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Holds a command across one edge; the caller ends with a no-op.
    task automatic run(input cpurg_pkg::cpurg_op_t op,
                       input logic [7:0] d8 = 8'h00,
                       input logic [15:0] d16 = 16'h0000,
                       input logic c = 1'b1);
        cmd = '{op, c, d8, d16};
        @(posedge i_sys_clk);
        #1;
    endtask

    // Resets, then answers the two vector reads one cycle late each.
    task automatic do_reset(input logic [15:0] v);
        i_rst = 1'b1;
        repeat (8) @(posedge i_sys_clk);
        #1;
        chk({hx[15:8], sp}, {8'h00, 16'h00FF});
        i_rst = 1'b0;
        @(posedge i_sys_clk);
        #1;
        chk({mem.rd, mem.addr}, {1'b1, 16'hFFFE});
        @(posedge i_sys_clk);
        #1;
        chk({mem.rd, mem.addr}, {1'b1, 16'hFFFF});
        rdata = v[15:8];
        @(posedge i_sys_clk);
        #1;
        rdata = v[7:0];
        @(posedge i_sys_clk);
        #1;
        chk({busy, pc}, {1'b0, v});
        $display("reset test done");
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial
    begin
        #50000;
        fail_count++;
        end_of_test();
    end

    // Main sequence: corner cases, random back-to-back work, then interrupt, call, data and reset checks.
    initial
    begin
        do_reset(16'hC0DE);
        run(cpurg_pkg::OP_LD_HX, 8'h00, 16'h12FE);
        run(cpurg_pkg::OP_X_INC);
        run(cpurg_pkg::OP_LD_CCR, 8'h00);
        chk({hx, condition_flags_reg[6:5]}, {16'h12FF, 2'b11});
        run(cpurg_pkg::OP_LD_SP, 8'h00, 16'h3A5C);
        s16 = sp;
        run(cpurg_pkg::OP_RSP);
        chk(sp, {s16[15:8], 8'hFF});
        s16 = pc;
        run(cpurg_pkg::OP_BRANCH, 8'h40, 16'h0000, 1'b0);
        chk(pc, s16);
        repeat (20)
        begin
            rnd = lfsr(rnd);
            s16 = sp;
            run(cpurg_pkg::OP_AIS, rnd[7:0]);
            chk(sp, 16'(s16 + sx(rnd[7:0])));
            run(cpurg_pkg::OP_LD_A, rnd[15:8]);
            run(cpurg_pkg::OP_LD_X, rnd[23:16]);
            run(cpurg_pkg::OP_MUL);
            chk({hx[7:0], acc}, rnd[15:8] * rnd[23:16]);
            s16 = pc;
            run(cpurg_pkg::OP_BRANCH, rnd[31:24]);
            chk(pc, 16'(s16 + sx(rnd[31:24])));
            run(cpurg_pkg::OP_FETCH);
            chk(pc, 16'(s16 + sx(rnd[31:24]) + 16'h0001));
            run(cpurg_pkg::OP_DIR_RD, rnd[7:0], 16'hFFFF);
            chk({mem.rd, mem.addr}, {1'b1, 8'h00, rnd[7:0]});
            s16 = sp;
            run(cpurg_pkg::OP_PUSH_A);
            chk({mem.wr, mem.wdata, mem.addr}, {1'b1, acc, s16});
            chk(sp, 16'(s16 - 16'h0001));
            run(cpurg_pkg::OP_JUMP, 8'h00, rnd[31:16]);
            chk(pc, rnd[31:16]);
        end
        $display("random test done");
        s16 = sp;
        frame = {condition_flags_reg, acc, hx[7:0], pc};
        run(cpurg_pkg::OP_IRQ, 8'h00, 16'h4000);
        // One frame byte per cycle; the mask rises with the last one.
        for (int i = 0; i < 5; i++)
        begin
            run(cpurg_pkg::OP_NOP);
            chk({mem.wr, condition_flags_reg[3], mem.addr, mem.wdata},
                {1'b1, i == 4, 16'(s16 - i), frame[8*i+:8]});
        end
        run(cpurg_pkg::OP_NOP);
        chk({busy, condition_flags_reg[3], sp}, {2'b01, s16 - 16'h0005});
        chk(pc, 16'h4000);
        s16 = sp;
        run(cpurg_pkg::OP_CALL, 8'h00, 16'h2345);
        run(cpurg_pkg::OP_LD_A, 8'h5A);
        chk({mem.wr, mem.addr, mem.wdata}, {1'b1, s16, 8'h00});
        run(cpurg_pkg::OP_NOP);
        chk({mem.addr, mem.wdata}, {16'(s16 - 16'h0001), 8'h40});
        chk({busy, acc, pc}, {1'b0, frame[31:24], 16'h2345});
        chk(sp, 16'(s16 - 16'h0002));
        $display("interrupt test done");
        for (int k = 7; k < 16; k++)
        begin
            rnd = lfsr(rnd);
            run(cpurg_pkg::OP_LD_X, rnd[7:0]);
            e9 = xop(cpurg_pkg::cpurg_op_t'(k), rnd[7:0], condition_flags_reg[0]);
            run(cpurg_pkg::cpurg_op_t'(k));
            chk({hx[7:0], condition_flags_reg[2:0]},
                {e9[7:0], e9[7], e9[7:0] == 8'h00, e9[8]});
        end
        run(cpurg_pkg::OP_LD_HX, 8'h00, 16'h0310);
        run(cpurg_pkg::OP_LD_A, 8'h45);
        run(cpurg_pkg::OP_DIV);
        chk({acc, hx[15:8], condition_flags_reg[0]}, {8'h34, 8'h05, 1'b0});
        run(cpurg_pkg::OP_LD_X, 8'h00);
        run(cpurg_pkg::OP_DIV);
        chk({acc, hx, condition_flags_reg[0]}, {8'h34, 8'h05, 8'h00, 1'b1});
        s16 = hx;
        run(cpurg_pkg::OP_IDX_RD, 8'h00, 16'h0123);
        chk({mem.rd, mem.addr}, {1'b1, 16'(s16 + 16'h0123)});
        run(cpurg_pkg::OP_LD_SP, 8'h00, 16'h01F0);
        run(cpurg_pkg::OP_PULL);
        chk({mem.rd, mem.wr, mem.addr}, {2'b10, 16'h01F1});
        chk(sp, 16'h01F1);
        run(cpurg_pkg::OP_NOP);
        $display("data test done");
        s16 = {acc, hx[7:0]};
        do_reset(rnd[15:0]);
        chk({acc, hx}, {s16[15:8], 8'h00, s16[7:0]});
        end_of_test();
    end
endmodule // cpu_programmer_model_regs_tb
`default_nettype wire
